//--- inc/ifm_consts.svh
// Purpose: constants of the interrupt flag and mask unit
// Assumes: register indices are word indices, byte address = 4 * index
// Notes:   included by the design file only
`ifndef IFM_CONSTS_SVH
`define IFM_CONSTS_SVH

// register indices
`define IFM_IDX_TIMER_FLAGS 8'h38
`define IFM_IDX_TIMER_MASK  8'h39
`define IFM_IDX_EXT_FLAGS   8'h3A
`define IFM_IDX_GEN_MASK    8'h3B
`define IFM_IDX_GLOBAL_CTRL 8'h3C

// reset values
`define IFM_RST_BYTE        8'h00
`define IFM_RST_GLOBAL      1'h0
`define IFM_RST_SRC         9'h000
`define IFM_RST_HOLD        16'h0000
`define IFM_RST_WORD        32'h0000_0000

// stored bits of the mask bytes
`define IFM_MASK_TIMER      8'hFD
`define IFM_MASK_GEN        8'hC0

// bit positions in the flag, mask and global control bytes
`define IFM_BIT_EXT1        7
`define IFM_BIT_EXT0        6
`define IFM_BIT_CNT2_CMP    7
`define IFM_BIT_CNT2_OVF    6
`define IFM_BIT_CNT1_CAP    5
`define IFM_BIT_CNT1_CMPA   4
`define IFM_BIT_CNT1_CMPB   3
`define IFM_BIT_CNT1_OVF    2
`define IFM_BIT_CNT0_OVF    0
`define IFM_BIT_GLOBAL_EN   7

// vector of source slot 0; slot k vectors to base + k
`define IFM_VEC_BASE        4'h1
`define IFM_NUM_SRC         9

`endif

//--- inc/ifm_pkg.sv
// Purpose: types shared by the interrupt flag and mask unit
// Assumes: constants live in ifm_consts.svh
// Notes:   slots are ordered by vector, lowest vector first
package ifm_pkg;

  typedef logic [7:0] ifm_byte_t;
  typedef logic [3:0] ifm_vec_t;
  typedef logic [8:0] ifm_src_t;

endpackage

//--- design/ifm_irq_unit.sv
// Purpose: pending flags, enables and vectored request for pin and timer
//          interrupt sources, with an APB register port
// Assumes: event inputs come from logic on pclk, one-cycle pulses
// Notes:   request and vector are registered; the core acknowledges
//          vector entry with irq_ack and returns with irq_return
//          an ack clears the slot shown on irq_vector, so a source that
//          outranks it one cycle late waits for the next entry
`timescale 1ns/1ps
`include "ifm_consts.svh"

module ifm_irq_unit #(
  parameter int ADDR_W = 10
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output      logic [31:0]         prdata,
  output      logic                pready,
  output      logic                pslverr,
  input  wire logic                ext1_event,
  input  wire logic                ext0_event,
  input  wire logic                cnt2_compare_event,
  input  wire logic                cnt2_overflow_event,
  input  wire logic                cnt2_tick,
  input  wire logic [7:0]          cnt2_count,
  input  wire logic                cnt2_pwm_mode,
  input  wire logic                capture_strobe,
  input  wire logic                cnt1_compare_a_event,
  input  wire logic                cnt1_compare_b_event,
  input  wire logic                cnt1_overflow_event,
  input  wire logic                cnt1_tick,
  input  wire logic [15:0]         cnt1_count,
  input  wire logic                cnt1_pwm_mode,
  input  wire logic                cnt0_overflow_event,
  output      logic [15:0]         cnt1_capture_hold,
  input  wire logic                irq_ack,
  input  wire logic                irq_return,
  output      logic                irq_req,
  output      logic [3:0]          irq_vector
);

  // lowest set slot wins, since slots are ordered by vector
  // a plain loop: priority is fixed, software cannot reorder it
  function automatic ifm_pkg::ifm_vec_t pick_vector(
    input ifm_pkg::ifm_src_t req
  );
    ifm_pkg::ifm_vec_t v;
    v = 4'h0;
    for (int k = `IFM_NUM_SRC - 1; k >= 0; k--)
    begin
      if (req[k])
        v = 4'(`IFM_VEC_BASE + 4'(k));
    end
    return v;
  endfunction

  // flag update: clear first, then set, so a set in the same cycle wins
  function automatic ifm_pkg::ifm_src_t flag_next(
    input ifm_pkg::ifm_src_t cur,
    input ifm_pkg::ifm_src_t set,
    input ifm_pkg::ifm_src_t clr
  );
    return (cur & ~clr) | set;
  endfunction

  ifm_pkg::ifm_src_t pending;
  ifm_pkg::ifm_byte_t timer_irq_mask;
  ifm_pkg::ifm_byte_t general_irq_mask;
  logic              global_en;

  // apb decode; bus_setup marks the access cycle still waiting for its
  // answer, bus_done the cycle in which the answer is taken
  wire logic              bus_setup;
  wire logic              bus_done;
  wire logic              aligned;
  wire logic              addr_high_zero;
  wire logic              word_ok;
  wire logic [7:0]        word_idx;
  wire logic              hit_tflag;
  wire logic              hit_tmask;
  wire logic              hit_eflag;
  wire logic              hit_gmask;
  wire logic              hit_gctl;
  wire logic              hit_any;
  wire logic              wr_done;
  wire ifm_pkg::ifm_byte_t wbyte;

  assign bus_setup = psel & penable & ~pready;
  assign bus_done  = psel & penable & pready;
  assign aligned   = (paddr[1:0] == 2'h0);
  // bits above the word index must be zero, else a wide bus would alias
  assign addr_high_zero = ~|(paddr >> 10);
  assign word_ok   = aligned & addr_high_zero;
  assign word_idx  = paddr[9:2];
  assign hit_tflag = word_ok & (word_idx == `IFM_IDX_TIMER_FLAGS);
  assign hit_tmask = word_ok & (word_idx == `IFM_IDX_TIMER_MASK);
  assign hit_eflag = word_ok & (word_idx == `IFM_IDX_EXT_FLAGS);
  assign hit_gmask = word_ok & (word_idx == `IFM_IDX_GEN_MASK);
  assign hit_gctl  = word_ok & (word_idx == `IFM_IDX_GLOBAL_CTRL);
  assign hit_any   = hit_tflag | hit_tmask | hit_eflag | hit_gmask | hit_gctl;
  assign wr_done   = bus_done & pwrite & hit_any;
  assign wbyte     = pwdata[7:0];

  // register views; unnamed and reserved bits tie to zero
  wire ifm_pkg::ifm_byte_t timer_irq_flags;
  wire ifm_pkg::ifm_byte_t external_irq_flags;
  wire ifm_pkg::ifm_byte_t rd_byte;

  // reserved bit 1 is a constant zero, so writes to it are lost
  assign timer_irq_flags = {pending[2], pending[3], pending[4], pending[5],
                            pending[6], pending[7], 1'h0,
                            pending[8]};
  assign external_irq_flags = {pending[1], pending[0], 6'h00};
  assign rd_byte = hit_tflag ? timer_irq_flags :
                   hit_tmask ? timer_irq_mask :
                   hit_eflag ? external_irq_flags :
                   hit_gmask ? general_irq_mask :
                   hit_gctl  ? {global_en, 7'h00} : 8'h00;

  // event sources in slot order: ext0, ext1, c2 cmp, c2 ovf, cap,
  // c1 cmp a, c1 cmp b, c1 ovf, c0 ovf
  wire logic              cnt2_ovf_set;
  wire logic              cnt1_ovf_set;
  wire ifm_pkg::ifm_src_t set_vec;

  // in pwm the counters turn at top, so overflow marks leaving zero
  // the count inputs carry the value before the tick
  assign cnt2_ovf_set = cnt2_pwm_mode ?
                        (cnt2_tick & (cnt2_count == 8'h00)) :
                        cnt2_overflow_event;
  assign cnt1_ovf_set = cnt1_pwm_mode ?
                        (cnt1_tick & (cnt1_count == 16'h0000)) :
                        cnt1_overflow_event;
  assign set_vec = {cnt0_overflow_event, cnt1_ovf_set, cnt1_compare_b_event,
                    cnt1_compare_a_event, capture_strobe, cnt2_ovf_set,
                    cnt2_compare_event, ext1_event,
                    ext0_event};

  // write-one clears; zero bits leave flags alone
  wire ifm_pkg::ifm_src_t wclr_vec;

  assign wclr_vec = {
    hit_tflag & wbyte[`IFM_BIT_CNT0_OVF],
    hit_tflag & wbyte[`IFM_BIT_CNT1_OVF],
    hit_tflag & wbyte[`IFM_BIT_CNT1_CMPB],
    hit_tflag & wbyte[`IFM_BIT_CNT1_CMPA],
    hit_tflag & wbyte[`IFM_BIT_CNT1_CAP],
    hit_tflag & wbyte[`IFM_BIT_CNT2_OVF],
    hit_tflag & wbyte[`IFM_BIT_CNT2_CMP],
    hit_eflag & wbyte[`IFM_BIT_EXT1],
    hit_eflag & wbyte[`IFM_BIT_EXT0]
  } & {`IFM_NUM_SRC{wr_done}};

  // hardware clear of the slot whose vector the core enters
  wire ifm_pkg::ifm_src_t ack_clr_vec;
  wire logic [3:0]        ack_slot;

  assign ack_slot = 4'(irq_vector - `IFM_VEC_BASE);
  assign ack_clr_vec = (irq_ack & irq_req) ?
                       ifm_pkg::ifm_src_t'(9'h001 << ack_slot) :
                       9'h000;

  // enables in slot order
  wire ifm_pkg::ifm_src_t en_vec;
  wire ifm_pkg::ifm_src_t live_vec;

  assign en_vec = {timer_irq_mask[`IFM_BIT_CNT0_OVF],
                   timer_irq_mask[`IFM_BIT_CNT1_OVF],
                   timer_irq_mask[`IFM_BIT_CNT1_CMPB],
                   timer_irq_mask[`IFM_BIT_CNT1_CMPA],
                   timer_irq_mask[`IFM_BIT_CNT1_CAP],
                   timer_irq_mask[`IFM_BIT_CNT2_OVF],
                   timer_irq_mask[`IFM_BIT_CNT2_CMP],
                   general_irq_mask[`IFM_BIT_EXT1],
                   general_irq_mask[`IFM_BIT_EXT0]};
  // a masked flag simply stays in pending until enabled or cleared
  assign live_vec = pending & en_vec & {`IFM_NUM_SRC{global_en}};

  // next values
  wire ifm_pkg::ifm_src_t next_pending;
  wire logic              next_global_en;
  wire logic              take_now;
  wire logic              sw_global_wr;
  wire logic              next_irq_req;
  wire ifm_pkg::ifm_vec_t next_irq_vector;

  assign next_pending = flag_next(pending, set_vec,
                                  wclr_vec | ack_clr_vec);
  assign take_now = irq_ack & irq_req;
  // software may set the enable inside a routine to allow nesting
  assign sw_global_wr = wr_done & hit_gctl;
  // entry clears global enable ahead of any software write or return
  assign next_global_en = take_now ? 1'h0 :
                          irq_return ? 1'h1 :
                          sw_global_wr ?
                            wbyte[`IFM_BIT_GLOBAL_EN] : global_en;
  // request drops the cycle after entry so one ack takes one vector
  assign next_irq_req = (|live_vec) & ~take_now;
  assign next_irq_vector = next_irq_req ? pick_vector(live_vec) : 4'h0;

  // pending flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending <= `IFM_RST_SRC;
    else
      pending <= next_pending;
  end

  // mask next values; reserved bits are never stored, so they read zero
  wire ifm_pkg::ifm_byte_t next_timer_irq_mask;
  wire ifm_pkg::ifm_byte_t next_general_irq_mask;

  assign next_timer_irq_mask = (wr_done & hit_tmask) ?
                               (wbyte & `IFM_MASK_TIMER) :
                               timer_irq_mask;
  assign next_general_irq_mask = (wr_done & hit_gmask) ?
                                 (wbyte & `IFM_MASK_GEN) :
                                 general_irq_mask;

  // timer mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_irq_mask <= `IFM_RST_BYTE;
    else
      timer_irq_mask <= next_timer_irq_mask;
  end

  // general mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      general_irq_mask <= `IFM_RST_BYTE;
    else
      general_irq_mask <= next_general_irq_mask;
  end

  // global enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      global_en <= `IFM_RST_GLOBAL;
    else
      global_en <= next_global_en;
  end

  // request to the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req    <= 1'b0;
      irq_vector <= 4'h0;
    end
    else
    begin
      irq_req    <= next_irq_req;
      irq_vector <= next_irq_vector;
    end
  end

  // capture copy taken on the same edge that raises the flag; a second
  // strobe before software reads the copy overwrites it
  wire logic [15:0]       next_cnt1_capture_hold;

  assign next_cnt1_capture_hold = capture_strobe ? cnt1_count :
                                  cnt1_capture_hold;

  // capture holding register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt1_capture_hold <= `IFM_RST_HOLD;
    else
      cnt1_capture_hold <= next_cnt1_capture_hold;
  end

  // apb answer values: one wait state keeps prdata a plain flop, at the
  // cost of a cycle on every access
  wire logic              next_pready;
  wire logic [31:0]       next_prdata;
  wire logic              next_pslverr;

  assign next_pready  = bus_setup;
  assign next_prdata  = bus_setup ? {24'h00_0000, rd_byte} : `IFM_RST_WORD;
  assign next_pslverr = bus_setup & ~hit_any;

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'h0;
      prdata  <= `IFM_RST_WORD;
      pslverr <= 1'h0;
    end
    else
    begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

//--- tb/ifm_chk.sv
// Purpose: timing checks on the bus and request ports
// Assumes: one apb wait state, registered request
// Notes:   bound to every ifm_irq_unit
`timescale 1ns/1ps
module ifm_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        capture_strobe,
  input wire logic [15:0] cnt1_count,
  input wire logic [15:0] cnt1_capture_hold,
  input wire logic        irq_ack,
  input wire logic        irq_req,
  input wire logic [3:0]  irq_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb setup, one wait state, one-cycle answer
  sequence setup_s; psel && !penable; endsequence
  sequence wait_s; !pready ##1 pready ##1 !pready; endsequence
  // entry taken with no bus write around it
  sequence taken_s; !pready && irq_ack && irq_req ##1 !pready; endsequence
  one_wait_a: assert property (setup_s |=> wait_s)
    else $error("apb answer timing wrong");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("slave error outside answer");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  vec_range_a: assert property (irq_req |-> irq_vector inside {[1:9]})
    else $error("vector out of range");
  vec_idle_a: assert property (!irq_req |-> irq_vector == 4'h0)
    else $error("vector without request");
  ack_drop_a: assert property (irq_ack && irq_req |=> !irq_req)
    else $error("request kept after entry");
  no_nest_a: assert property (taken_s |=> !irq_req)
    else $error("global enable kept after entry");
  cap_copy_a: assert property (capture_strobe |=>
    cnt1_capture_hold == $past(cnt1_count))
    else $error("capture value not held");
endmodule
bind ifm_irq_unit ifm_chk ifm_chk_i (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .prdata, .capture_strobe, .cnt1_count,
  .cnt1_capture_hold, .irq_ack, .irq_req, .irq_vector);

//--- tb/ifm_core_model.sv
// Purpose: cpu core stand-in that enters and leaves vectors
// Assumes: ack is a one-cycle pulse, taken while irq_req is high
// Notes:   ack_wait stretches the stall before entry
`timescale 1ns/1ps
module ifm_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_vector,
  input  wire logic [2:0] ack_wait,
  output      logic       irq_ack,
  output      logic       irq_return,
  output      logic       entry,
  output      logic [3:0] entry_vec
);
  logic [2:0] cnt;
  logic [2:0] run;
  // stall, enter, run a short routine, then return
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt <= 3'h0;
      run <= 3'h0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      entry <= 1'b0;
      entry_vec <= 4'h0;
    end
    else
    begin
      irq_ack <= 1'b0;
      irq_return <= run == 3'h1;
      entry <= irq_ack && irq_req;
      if (irq_ack && irq_req)
      begin
        entry_vec <= irq_vector;
        run <= 3'h4;
      end
      else if (run != 3'h0)
        run <= run - 3'h1;
      else if (irq_req)
      begin
        cnt <= cnt == ack_wait ? 3'h0 : cnt + 3'h1;
        irq_ack <= cnt == ack_wait;
      end
    end
endmodule

//--- tb/ifm_irq_unit_tb.sv
// Purpose: self-checking bench of ifm_irq_unit
// Assumes: core model answers requests, bench drives apb and events
// Notes:   fixed seed keeps the random values repeatable
`timescale 1ns/1ps
module ifm_irq_unit_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0, pwm = 1'b0;
  logic [9:0]  paddr = 10'h0;
  logic [31:0] pwdata = 32'h0, prdata, q, v;
  logic        pready, pslverr, e, irq_ack, irq_return, irq_req, ent;
  logic [10:0] ev = 11'h0;
  logic [7:0]  c2 = 8'h0;
  logic [15:0] c1 = 16'h0, cnt1_capture_hold;
  logic [2:0]  wt = 3'h0;
  logic [3:0]  irq_vector, evec;
  integer      seed = 32'h95A4;
  int          mismatches = 0;
  int          n_compared = 0;
  always #25 pclk = ~pclk;
  ifm_irq_unit #(.ADDR_W(10)) ifm_irq_unit_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext1_event(ev[1]), .ext0_event(ev[0]), .cnt2_compare_event(ev[2]),
    .cnt2_overflow_event(ev[3]), .cnt2_tick(ev[9]), .cnt2_count(c2),
    .cnt2_pwm_mode(pwm), .capture_strobe(ev[4]), .cnt1_tick(ev[10]),
    .cnt1_compare_a_event(ev[5]), .cnt1_compare_b_event(ev[6]),
    .cnt1_overflow_event(ev[7]), .cnt1_count(c1), .cnt1_pwm_mode(pwm),
    .cnt0_overflow_event(ev[8]), .cnt1_capture_hold, .irq_ack,
    .irq_return, .irq_req, .irq_vector);
  ifm_core_model ifm_core_model_i (.pclk, .presetn, .irq_req,
    .irq_vector, .ack_wait(wt), .irq_ack, .irq_return, .entry(ent),
    .entry_vec(evec));
  // timer flag byte expected from a set of source slots
  function automatic logic [7:0] tf_of(logic [8:0] s);
    return {s[2], s[3], s[4], s[5], s[6], s[7], 1'b0, s[8]};
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      $display("wrong value %s expected %h seen %h", nm, x, g);
      mismatches++;
    end
  endtask
  // bounded wait, a hang ends the run
  task automatic until1(ref logic s);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge pclk);
      if (s === 1'b1) break;
    end
    if (n == 40) mismatches++;
    if (n == 40) tally_and_finish();
  endtask
  // request held until pready is sampled high, then an idle cycle
  task automatic apb(logic w, logic [9:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    until1(pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(logic [9:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read data", x, q);
  endtask
  task automatic fire(logic [10:0] s);
    ev <= s;
    @(posedge pclk);
    ev <= 11'h0;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rd(10'h0E0 + 10'(4 * i), 32'h0);
    apb(1'b0, 10'h100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b0, 10'h0E1, 32'h0);
    chk("misaligned error", 32'h1, {31'h0, e});
    apb(1'b1, 10'h0E4, 32'hFF);
    rd(10'h0E4, 32'hFD);
    apb(1'b1, 10'h0EC, 32'hFF);
    rd(10'h0EC, 32'hC0);
    fire(11'h1FF);
    rd(10'h0E0, {24'h0, tf_of(9'h1FF)});
    rd(10'h0E8, 32'hC0);
    apb(1'b1, 10'h0E0, 32'h0);
    rd(10'h0E0, 32'hFD);
    // pin 0 event lands on the edge that takes a write-one clear
    fork
      apb(1'b1, 10'h0E8, 32'hC0);
      begin
        repeat (2) @(posedge pclk);
        fire(11'h001);
      end
    join
    rd(10'h0E8, 32'h40);
    fire(11'h002);
    $display("end of test: registers and pending flags");
    wt <= 3'($random(seed));
    apb(1'b1, 10'h0F0, 32'h80);
    for (int k = 1; k < 10; k++)
    begin
      until1(ent);
      chk("vector", k, {28'h0, evec});
    end
    rd(10'h0E0, 32'h0);
    rd(10'h0E8, 32'h0);
    rd(10'h0F0, 32'h80);
    apb(1'b1, 10'h0F0, 32'h0);
    fire(11'h1FF);
    v = $random(seed);
    apb(1'b1, 10'h0E0, v);
    rd(10'h0E0, {24'h0, 8'hFD & ~v[7:0]});
    apb(1'b1, 10'h0E8, v);
    rd(10'h0E8, {24'h0, 8'hC0 & ~v[7:0]});
    $display("end of test: priority and clearing");
    apb(1'b1, 10'h0E0, 32'hFF);
    pwm <= 1'b1;
    c2 <= 8'($random(seed)) | 8'h1;
    c1 <= 16'($random(seed)) | 16'h1;
    fire(11'h688);
    rd(10'h0E0, 32'h0);
    c2 <= 8'h0;
    c1 <= 16'h0;
    fire(11'h600);
    rd(10'h0E0, 32'h44);
    pwm <= 1'b0;
    c1 <= 16'($random(seed));
    fire(11'h010);
    @(posedge pclk);
    chk("capture hold", {16'h0, c1}, {16'h0, cnt1_capture_hold});
    rd(10'h0E0, 32'h64);
    $display("end of test: pwm and capture");
    tally_and_finish();
  end
endmodule
